//--- rtl/aibl_loader.sv
// Adapter initialization-block loader: host window, validation, DMA test, config
//
// How it works
// - Both parity bits set: odd parity checked on data-port writes into the block and DMA.
// - Command/status block burst option: 6-byte read, 2-byte clear, 8-byte write.
// - List burst option fetches lists in 26-byte bursts, else cycle steal.
// - List-status burst option selects burst write-back of list status.
// - Receive-data burst option selects bursts capped by receive burst size.
// - Transmit-data burst option selects bursts capped by transmit burst size.
// - Link-layer bit enables the link-layer interface; needs that firmware present.
// - Command-status, transmit, receive vectors driven on matching status updates.
// - Ring-status vector for ring, link, timer; separate free and fatal vectors.
// - Receive burst cap; zero means all, ignored in cycle steal, must be even.
// - Transmit burst cap applies always; zero means all; must be even.
// - Abort word: high byte bus-error attempts, low byte parity-error attempts.
// - Each data-port write lands at the next RAM location.
// - Success clears initialize, test, error; block patterns stay in host memory.
// - Failure sets error and the code field; only reset recovers.
// - A test transfer stuck for 11 seconds reports a DMA timeout.
// - DMA test writes then reads back both blocks and compares.
//
// Decided for this implementation: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`include "aibl_regs.svh"
module aibl_loader #(
  parameter int unsigned DMA_TMO_CYC = `AIBL_DMA_TMO_S * `AIBL_CLK_HZ
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // Register port
  input wire logic [2:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wpar,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  // Firmware presence
  input wire logic i_llc_present,
  // Host DMA channel
  output logic o_dma_req,
  output logic o_dma_write,
  output logic [31:0] o_dma_addr,
  output logic [15:0] o_dma_wdata,
  output logic o_dma_burst,
  output logic [7:0] o_dma_len,
  input wire logic i_dma_done,
  input wire logic [15:0] i_dma_rdata,
  input wire logic i_dma_bus_err,
  input wire logic i_dma_par_err,
  // Run-time configuration
  output logic o_cfg_valid,
  output logic o_parity_on,
  output logic o_cmd_stat_block_burst,
  output logic o_list_burst,
  output logic [7:0] o_list_len,
  output logic o_lstat_burst,
  output logic o_rx_burst,
  output logic o_tx_burst,
  output logic o_link_layer_on,
  output logic [15:0] o_rx_burst_cap,
  output logic [15:0] o_tx_burst_cap,
  output logic [7:0] o_bus_err_tries,
  output logic [7:0] o_par_err_tries,
  // Interrupt vector onto the host bus
  input wire aibl_pkg::aibl_irq_ev_t i_irq_event,
  output logic [7:0] o_irq_vec,
  output logic o_irq_vec_valid
);
  import aibl_pkg::*;
  aibl_cfg_if cfg ();
  aibl_state_t state;
  logic [15:0] host_ext_address_reg;
  logic [15:0] host_address_reg;
  logic [15:0] blk [`AIBL_BLK_WORDS];
  logic [`AIBL_BLK_WORDS-1:0] wrote;
  logic dio_par_err;
  logic sts_init;
  logic sts_err;
  aibl_code_t sts_code;
  logic sys_int;
  logic start;
  // ----------------------------------------
  // Register decode
  // ----------------------------------------
  wire wr_cmd = i_wr && (i_addr == `AIBL_OFS_CMDSTS);
  wire wr_adr = i_wr && (i_addr == `AIBL_OFS_ADR);
  wire wr_dat = i_wr && (i_addr == `AIBL_OFS_DAT);
  wire wr_adx = i_wr && (i_addr == `AIBL_OFS_ADX);
  wire rd_dat = i_rd && (i_addr == `AIBL_OFS_DAT);
  wire [15:0] blk_off = host_address_reg - `AIBL_BLK_ADR;
  wire in_blk = (host_ext_address_reg == `AIBL_BLK_ADX) && (host_address_reg >= `AIBL_BLK_ADR)
                && (blk_off < `AIBL_BLK_BYTES) && !host_address_reg[0];
  wire [3:0] widx = blk_off[4:1];
  wire par_bad = !(^{i_wdata, i_wpar});
  wire go = wr_cmd && i_wdata[`AIBL_CMD_INT_ADAPTER] && i_wdata[`AIBL_CMD_EXECUTE]
            && (state == ST_IDLE) && sts_init;
  wire [15:0] sts_word = {8'h00, sys_int, sts_init, 1'b0, sts_err, sts_code};
  wire [15:0] rd_val = (i_addr == `AIBL_OFS_CMDSTS) ? sts_word :
                       (i_addr == `AIBL_OFS_ADR) ? host_address_reg :
                       (i_addr == `AIBL_OFS_ADX) ? host_ext_address_reg :
                       (i_addr == `AIBL_OFS_DAT && in_blk) ? blk[widx] : 16'h0000;
  // ----------------------------------------
  // Host address window
  // ----------------------------------------
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
      host_ext_address_reg <= 16'h0000;
    else if (wr_adx)
      host_ext_address_reg <= i_wdata;
  end
  // Reads of the data port step the address too, so the block image streams out
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
      host_address_reg <= 16'h0000;
    else if (wr_adr)
      host_address_reg <= i_wdata;
    else if (wr_dat || rd_dat)
      host_address_reg <= host_address_reg + 16'h0002;
  end
  // ----------------------------------------
  // Block RAM image
  // ----------------------------------------
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      wrote <= '0;
      dio_par_err <= 1'b0;
      for (int i = 0; i < `AIBL_BLK_WORDS; i++)
        blk[i] <= 16'h0000;
    end
    else if (wr_dat && in_blk)
    begin
      blk[widx] <= i_wdata;
      wrote[widx] <= 1'b1;
      dio_par_err <= dio_par_err | par_bad;
    end
  end
  for (genvar g = 0; g < `AIBL_BLK_WORDS; g++)
  begin : g_blk
    assign cfg.blk[g] = blk[g];
  end
  assign cfg.all_written = &wrote;
  assign cfg.dio_par_err = dio_par_err;
  assign cfg.llc_present = i_llc_present;
  assign cfg.start = start;
  // ----------------------------------------
  // Initialization sequence and status
  // ----------------------------------------
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      state <= ST_IDLE;
      start <= 1'b0;
      sts_init <= `AIBL_STS_INIT_RST;
      sts_err <= 1'b0;
      sts_code <= `AIBL_E_NONE;
    end
    else
    begin
      start <= 1'b0;
      unique case (state)
        ST_IDLE:
          if (go)
            state <= ST_CHECK;
        ST_CHECK:
          if (cfg.chk_code != `AIBL_E_NONE)
          begin
            sts_err <= 1'b1;
            sts_code <= cfg.chk_code;
            state <= ST_FAIL;
          end
          else
          begin
            start <= 1'b1;
            state <= ST_TEST;
          end
        ST_TEST:
          if (cfg.tst_done && !start)
          begin
            if (cfg.tst_code != `AIBL_E_NONE)
            begin
              sts_err <= 1'b1;
              sts_code <= cfg.tst_code;
              state <= ST_FAIL;
            end
            else
            begin
              sts_init <= 1'b0;
              state <= ST_DONE;
            end
          end
        // Only a reset leaves these
        ST_DONE, ST_FAIL:
          state <= state;
      endcase
    end
  end
  // A vector going out raises the system interrupt; a set beats a same-cycle clear
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
      sys_int <= 1'b0;
    else if (o_irq_vec_valid)
      sys_int <= 1'b1;
    else if (wr_cmd && !i_wdata[`AIBL_CMD_SYS_INT])
      sys_int <= 1'b0;
  end
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
      o_rdata <= 16'h0000;
    else
      o_rdata <= i_rd ? rd_val : 16'h0000;
  end
  // ----------------------------------------
  // Run-time configuration, valid only after success
  // ----------------------------------------
  wire cfg_ok = state == ST_DONE;
  wire [15:0] opt = blk[`AIBL_W_OPT];
  wire rxb = opt[`AIBL_OPT_RX_BURST];
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst || !cfg_ok)
    begin
      o_cfg_valid <= 1'b0;
      o_parity_on <= 1'b0;
      o_cmd_stat_block_burst <= 1'b0;
      o_list_burst <= 1'b0;
      o_list_len <= 8'h00;
      o_lstat_burst <= 1'b0;
      o_rx_burst <= 1'b0;
      o_tx_burst <= 1'b0;
      o_link_layer_on <= 1'b0;
      o_rx_burst_cap <= 16'h0000;
      o_tx_burst_cap <= 16'h0000;
      o_bus_err_tries <= 8'h00;
      o_par_err_tries <= 8'h00;
    end
    else
    begin
      o_cfg_valid <= 1'b1;
      o_parity_on <= opt[`AIBL_OPT_PAR_A] & opt[`AIBL_OPT_PAR_B];
      o_cmd_stat_block_burst <= opt[`AIBL_OPT_CSB_BURST];
      o_list_burst <= opt[`AIBL_OPT_LIST_BURST];
      o_list_len <= opt[`AIBL_OPT_LIST_BURST] ? `AIBL_LIST_BYTES : `AIBL_STEAL_BYTES;
      o_lstat_burst <= opt[`AIBL_OPT_LSTAT_BURST];
      o_rx_burst <= rxb;
      o_tx_burst <= opt[`AIBL_OPT_TX_BURST];
      o_link_layer_on <= opt[`AIBL_OPT_LLC];
      // Cycle steal ignores the receive cap, so it reads as zero then
      o_rx_burst_cap <= rxb ? blk[`AIBL_W_RXB] : 16'h0000;
      o_tx_burst_cap <= blk[`AIBL_W_TXB];
      o_bus_err_tries <= blk[`AIBL_W_ABT][15:8];
      o_par_err_tries <= blk[`AIBL_W_ABT][7:0];
    end
  end
  // ----------------------------------------
  // Interrupt vector selection
  // ----------------------------------------
  wire [15:0] v1 = blk[`AIBL_W_VEC_CS_TX];
  wire [15:0] v2 = blk[`AIBL_W_VEC_RX_RING];
  wire [15:0] v3 = blk[`AIBL_W_VEC_FREE_FATAL];
  wire [7:0] vec_sel =
    (i_irq_event == EV_CMD_STATUS) ? v1[15:8] :
    (i_irq_event == EV_TRANSMIT) ? v1[7:0] :
    (i_irq_event == EV_RECEIVE || i_irq_event == EV_RX_PENDING) ? v2[15:8] :
    (i_irq_event == EV_CMD_FREED) ? v3[15:8] :
    (i_irq_event == EV_FATAL) ? v3[7:0] : v2[7:0];
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      o_irq_vec <= 8'h00;
      o_irq_vec_valid <= 1'b0;
    end
    else
    begin
      o_irq_vec_valid <= cfg_ok && (i_irq_event != EV_NONE);
      o_irq_vec <= (cfg_ok && i_irq_event != EV_NONE) ? vec_sel : 8'h00;
    end
  end
  // ----------------------------------------
  // Submodules
  // ----------------------------------------
  aibl_check u_check (
    .cfg(cfg.chk)
  );
  aibl_dma_test #(
    .TMO_CYC(DMA_TMO_CYC)
  ) u_dma_test (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .cfg(cfg.tst),
    .o_dma_req(o_dma_req),
    .o_dma_write(o_dma_write),
    .o_dma_addr(o_dma_addr),
    .o_dma_wdata(o_dma_wdata),
    .o_dma_burst(o_dma_burst),
    .o_dma_len(o_dma_len),
    .i_dma_done(i_dma_done),
    .i_dma_rdata(i_dma_rdata),
    .i_dma_bus_err(i_dma_bus_err),
    .i_dma_par_err(i_dma_par_err)
  );
endmodule : aibl_loader

//--- rtl/aibl_regs.svh
// Offsets, field positions, reset values and timing counts of the init-block loader
`ifndef AIBL_REGS_SVH
`define AIBL_REGS_SVH
// ----------------------------------------
// Register port byte offsets
// ----------------------------------------
`define AIBL_OFS_CMDSTS 3'h0
`define AIBL_OFS_ADR 3'h2
`define AIBL_OFS_DAT 3'h4
`define AIBL_OFS_ADX 3'h6
// ----------------------------------------
// Command/status bit positions
// ----------------------------------------
`define AIBL_CMD_INT_ADAPTER 15
`define AIBL_CMD_EXECUTE 12
`define AIBL_CMD_SYS_INT 7
`define AIBL_STS_INIT_RST 1'b1
// ----------------------------------------
// Block placement in adapter RAM
// ----------------------------------------
`define AIBL_BLK_ADX 16'h0001
`define AIBL_BLK_ADR 16'h0a00
`define AIBL_BLK_BYTES 16'h0016
`define AIBL_BLK_WORDS 11
`define AIBL_W_OPT 0
`define AIBL_W_VEC_CS_TX 1
`define AIBL_W_VEC_RX_RING 2
`define AIBL_W_VEC_FREE_FATAL 3
`define AIBL_W_RXB 4
`define AIBL_W_TXB 5
`define AIBL_W_ABT 6
`define AIBL_W_SCBH 7
`define AIBL_W_SCBL 8
`define AIBL_W_SSBH 9
`define AIBL_W_SSBL 10
// ----------------------------------------
// Option word bits (option bit n sits at vector position 15-n)
// ----------------------------------------
`define AIBL_OPT_ONE 15
`define AIBL_OPT_PAR_A 14
`define AIBL_OPT_PAR_B 13
`define AIBL_OPT_CSB_BURST 12
`define AIBL_OPT_LIST_BURST 11
`define AIBL_OPT_LSTAT_BURST 10
`define AIBL_OPT_RX_BURST 9
`define AIBL_OPT_TX_BURST 8
`define AIBL_OPT_RSV8 7
`define AIBL_OPT_LLC 6
`define AIBL_OPT_RSV_MASK 16'h003f
// ----------------------------------------
// Initialization error codes
// ----------------------------------------
`define AIBL_E_NONE 4'h0
`define AIBL_E_SHORT 4'h1
`define AIBL_E_OPT 4'h2
`define AIBL_E_RXB 4'h3
`define AIBL_E_TXB 4'h4
`define AIBL_E_ABT 4'h5
`define AIBL_E_SCB 4'h6
`define AIBL_E_SSB 4'h7
`define AIBL_E_DIOPAR 4'h8
`define AIBL_E_TMO 4'h9
`define AIBL_E_DMAPAR 4'ha
`define AIBL_E_BUS 4'hb
`define AIBL_E_DATA 4'hc
// ----------------------------------------
// DMA burst lengths in bytes and test patterns
// ----------------------------------------
`define AIBL_SCB_RD_BYTES 8'h06
`define AIBL_SCB_CLR_BYTES 8'h02
`define AIBL_SSB_BYTES 8'h08
`define AIBL_LIST_BYTES 8'h1a
`define AIBL_STEAL_BYTES 8'h02
`define AIBL_PAT 112'h0000c1e2d48bffffd1d7c5d9c3d4
// ----------------------------------------
// Timing
// ----------------------------------------
`define AIBL_CLK_HZ 40000000
`define AIBL_DMA_TMO_S 11
`endif

//--- rtl/aibl_pkg.sv
// Types shared by the init-block loader modules
package aibl_pkg;
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_CHECK = 5'b00010,
    ST_TEST = 5'b00100,
    ST_DONE = 5'b01000,
    ST_FAIL = 5'b10000
  } aibl_state_t;
  typedef enum logic [2:0] {
    T_IDLE = 3'b001,
    T_REQ = 3'b010,
    T_WAIT = 3'b100
  } aibl_tst_state_t;
  typedef enum logic [3:0] {
    EV_NONE = 4'h0,
    EV_CMD_STATUS = 4'h1,
    EV_TRANSMIT = 4'h2,
    EV_RECEIVE = 4'h3,
    EV_RX_PENDING = 4'h4,
    EV_RING_STATUS = 4'h5,
    EV_LLC_STATUS = 4'h6,
    EV_TIMER = 4'h7,
    EV_CMD_FREED = 4'h8,
    EV_FATAL = 4'h9
  } aibl_irq_ev_t;
  typedef logic [3:0] aibl_code_t;
endpackage : aibl_pkg

//--- rtl/aibl_cfg_if.sv
// Interface carrying the loaded block and test control between loader modules
`timescale 1ns/1ps
`include "aibl_regs.svh"
interface aibl_cfg_if;
  import aibl_pkg::*;
  logic [15:0] blk [`AIBL_BLK_WORDS];
  logic all_written;
  logic dio_par_err;
  logic llc_present;
  logic start;
  aibl_code_t chk_code;
  aibl_code_t tst_code;
  logic tst_done;
  modport top (output blk, all_written, dio_par_err, llc_present, start,
               input chk_code, tst_code, tst_done);
  modport chk (input blk, all_written, dio_par_err, llc_present, output chk_code);
  modport tst (input blk, start, output tst_code, tst_done);
endinterface : aibl_cfg_if

//--- rtl/aibl_check.sv
// Field validation of the loaded initialization block
`timescale 1ns/1ps
`include "aibl_regs.svh"
module aibl_check (
  // Loaded block and verdict
  aibl_cfg_if.chk cfg
);
  import aibl_pkg::*;
  wire [15:0] opt = cfg.blk[`AIBL_W_OPT];
  wire par_mix = opt[`AIBL_OPT_PAR_A] != opt[`AIBL_OPT_PAR_B];
  wire par_on = opt[`AIBL_OPT_PAR_A] & opt[`AIBL_OPT_PAR_B];
  wire llc_bad = opt[`AIBL_OPT_LLC] && !cfg.llc_present;
  wire rsv_bad = !opt[`AIBL_OPT_ONE] || opt[`AIBL_OPT_RSV8] || |(opt & `AIBL_OPT_RSV_MASK);
  wire opt_bad = rsv_bad || par_mix || llc_bad;
  // ----------------------------------------
  // First violation wins, in error-code order
  // ----------------------------------------
  assign cfg.chk_code =
    !cfg.all_written ? `AIBL_E_SHORT :
    opt_bad ? `AIBL_E_OPT :
    cfg.blk[`AIBL_W_RXB][0] ? `AIBL_E_RXB :
    cfg.blk[`AIBL_W_TXB][0] ? `AIBL_E_TXB :
    (cfg.blk[`AIBL_W_ABT] == 16'h0000) ? `AIBL_E_ABT :
    cfg.blk[`AIBL_W_SCBL][0] ? `AIBL_E_SCB :
    cfg.blk[`AIBL_W_SSBL][0] ? `AIBL_E_SSB :
    (par_on && cfg.dio_par_err) ? `AIBL_E_DIOPAR :
    `AIBL_E_NONE;
endmodule : aibl_check

//--- rtl/aibl_dma_test.sv
// DMA write/read-back test of the command and status blocks
`timescale 1ns/1ps
`include "aibl_regs.svh"
module aibl_dma_test #(
  parameter int unsigned TMO_CYC = 1
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // Block contents and test control
  aibl_cfg_if.tst cfg,
  // Host DMA channel
  output logic o_dma_req,
  output logic o_dma_write,
  output logic [31:0] o_dma_addr,
  output logic [15:0] o_dma_wdata,
  output logic o_dma_burst,
  output logic [7:0] o_dma_len,
  input wire logic i_dma_done,
  input wire logic [15:0] i_dma_rdata,
  input wire logic i_dma_bus_err,
  input wire logic i_dma_par_err
);
  import aibl_pkg::*;
  localparam logic [3:0] NWR = 4'd7;
  localparam logic [3:0] LAST = 4'd13;
  localparam logic [111:0] PAT = `AIBL_PAT;
  aibl_tst_state_t state;
  logic [3:0] idx;
  logic [7:0] bus_try;
  logic [7:0] par_try;
  logic [31:0] tmo;
  logic [15:0] pat_w [7];
  // Seven words: three command-block words, then four status-block words
  for (genvar g = 0; g < 7; g++)
  begin : g_pat
    assign pat_w[g] = PAT[111 - 16 * g -: 16];
  end
  wire is_wr = idx < NWR;
  wire [3:0] widx = is_wr ? idx : idx - NWR;
  wire in_ssb = widx >= 4'd3;
  wire [3:0] woff = in_ssb ? widx - 4'd3 : widx;
  wire [31:0] host_command_block = {cfg.blk[`AIBL_W_SCBH], cfg.blk[`AIBL_W_SCBL]};
  wire [31:0] host_status_block = {cfg.blk[`AIBL_W_SSBH], cfg.blk[`AIBL_W_SSBL]};
  wire [31:0] addr = (in_ssb ? host_status_block : host_command_block) + {27'h0, woff, 1'b0};
  wire [15:0] opt = cfg.blk[`AIBL_W_OPT];
  wire burst = opt[`AIBL_OPT_CSB_BURST];
  wire par_on = opt[`AIBL_OPT_PAR_A] & opt[`AIBL_OPT_PAR_B];
  wire [7:0] len = !burst ? `AIBL_STEAL_BYTES : in_ssb ? `AIBL_SSB_BYTES :
                   is_wr ? `AIBL_SCB_CLR_BYTES : `AIBL_SCB_RD_BYTES;
  wire [7:0] bus_lim = cfg.blk[`AIBL_W_ABT][15:8];
  wire [7:0] par_lim = cfg.blk[`AIBL_W_ABT][7:0];
  wire bus_out = ({1'b0, bus_try} + 9'd1) >= {1'b0, bus_lim};
  wire par_out = ({1'b0, par_try} + 9'd1) >= {1'b0, par_lim};
  wire par_hit = i_dma_par_err && par_on;
  wire miss = !is_wr && (i_dma_rdata != pat_w[widx[2:0]]);
  wire tmo_hit = tmo >= TMO_CYC;
  // ----------------------------------------
  // Test sequencer
  // ----------------------------------------
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      state <= T_IDLE;
      idx <= 4'd0;
      bus_try <= 8'h00;
      par_try <= 8'h00;
      tmo <= 32'h0;
      cfg.tst_done <= 1'b0;
      cfg.tst_code <= `AIBL_E_NONE;
      o_dma_req <= 1'b0;
      o_dma_write <= 1'b0;
      o_dma_addr <= 32'h0;
      o_dma_wdata <= 16'h0000;
      o_dma_burst <= 1'b0;
      o_dma_len <= 8'h00;
    end
    else
    begin
      o_dma_req <= 1'b0;
      unique case (state)
        T_IDLE:
        begin
          if (cfg.start)
          begin
            idx <= 4'd0;
            bus_try <= 8'h00;
            par_try <= 8'h00;
            cfg.tst_done <= 1'b0;
            state <= T_REQ;
          end
        end
        T_REQ:
        begin
          o_dma_req <= 1'b1;
          o_dma_write <= is_wr;
          o_dma_addr <= addr;
          o_dma_wdata <= is_wr ? pat_w[widx[2:0]] : 16'h0000;
          o_dma_burst <= burst;
          o_dma_len <= len;
          tmo <= 32'h0;
          state <= T_WAIT;
        end
        T_WAIT:
        begin
          tmo <= tmo + 32'h1;
          if (i_dma_done)
          begin
            state <= T_REQ;
            if (i_dma_bus_err)
            begin
              bus_try <= bus_try + 8'h01;
              if (bus_out)
              begin
                cfg.tst_code <= `AIBL_E_BUS;
                cfg.tst_done <= 1'b1;
                state <= T_IDLE;
              end
            end
            else if (par_hit)
            begin
              par_try <= par_try + 8'h01;
              if (par_out)
              begin
                cfg.tst_code <= `AIBL_E_DMAPAR;
                cfg.tst_done <= 1'b1;
                state <= T_IDLE;
              end
            end
            else if (miss || idx == LAST)
            begin
              cfg.tst_code <= miss ? `AIBL_E_DATA : `AIBL_E_NONE;
              cfg.tst_done <= 1'b1;
              state <= T_IDLE;
            end
            else
            begin
              idx <= idx + 4'd1;
              bus_try <= 8'h00;
              par_try <= 8'h00;
            end
          end
          else if (tmo_hit)
          begin
            cfg.tst_code <= `AIBL_E_TMO;
            cfg.tst_done <= 1'b1;
            state <= T_IDLE;
          end
        end
      endcase
    end
  end
endmodule : aibl_dma_test

//--- testbench/aibl_loader_chk.sv
// Concurrent checks on the init-block loader ports
`timescale 1ns/1ps
module aibl_loader_chk (
  // Clock, reset and register port
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic [2:0] i_addr,
  input wire logic i_rd,
  input wire logic [15:0] o_rdata,
  // DMA channel
  input wire logic o_dma_req,
  input wire logic o_dma_burst,
  input wire logic [7:0] o_dma_len,
  input wire logic i_dma_done,
  // Configuration and vectors
  input wire logic o_cfg_valid,
  input wire logic o_list_burst,
  input wire logic [7:0] o_list_len,
  input wire logic o_rx_burst,
  input wire logic [15:0] o_rx_burst_cap,
  input wire aibl_pkg::aibl_irq_ev_t i_irq_event,
  input wire logic o_irq_vec_valid
);
  import aibl_pkg::*;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  sequence s_req;
    o_dma_req ##1 !o_dma_req;
  endsequence
  property p_req_pulse; o_dma_req |-> s_req; endproperty
  a_req_pulse: assert property (p_req_pulse) else $error("dma req too long");
  property p_pass_done; $rose(o_cfg_valid) |-> $past(i_dma_done, 3); endproperty
  a_pass_done: assert property (p_pass_done) else $error("pass without test end");
  property p_cfg_hold; o_cfg_valid |=> o_cfg_valid; endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("config dropped");
  property p_err_code; i_rd && i_addr == 3'h0 |=> o_rdata[4] == (o_rdata[3:0] != 4'h0); endproperty
  a_err_code: assert property (p_err_code) else $error("error bit and code disagree");
  property p_list_len; o_cfg_valid |-> o_list_len == (o_list_burst ? 8'h1a : 8'h02); endproperty
  a_list_len: assert property (p_list_len) else $error("list length wrong");
  property p_rx_cap; o_cfg_valid && !o_rx_burst |-> o_rx_burst_cap == 16'h0; endproperty
  a_rx_cap: assert property (p_rx_cap) else $error("rx cap in steal mode");
  property p_steal_len; o_dma_req && !o_dma_burst |-> o_dma_len == 8'h02; endproperty
  a_steal_len: assert property (p_steal_len) else $error("steal length wrong");
  property p_irq_go; o_cfg_valid && i_irq_event != EV_NONE |=> o_irq_vec_valid; endproperty
  a_irq_go: assert property (p_irq_go) else $error("vector missing");
endmodule : aibl_loader_chk
bind aibl_loader aibl_loader_chk u_chk (.*);

//--- testbench/aibl_host_mdl.sv
// Host memory and DMA responder facing the loader
`timescale 1ns/1ps
module aibl_host_mdl (
  // Clock and DMA channel
  input wire logic i_ref_clk,
  input wire logic i_req,
  input wire logic i_write,
  input wire logic [31:0] i_addr,
  input wire logic [15:0] i_wdata,
  // Behaviour: 0 prompt, 1 slow, 2 corrupt reads, 3 silent
  input wire logic [1:0] i_mode,
  output logic o_done,
  output logic [15:0] o_rdata
);
  logic [15:0] mem [logic [31:0]];
  initial o_done = 1'b0;
  initial o_rdata = 16'h0;
  always @(posedge i_ref_clk)
  begin
    o_done <= 1'b0;
    // Idle data wobbles so stale values never match
    o_rdata <= ~o_rdata;
    if (i_req && i_mode != 2'h3)
    begin
      if (i_write)
        mem[i_addr] = i_wdata;
      repeat ((i_mode == 2'h1) ? 5 : 1) @(posedge i_ref_clk);
      o_done <= 1'b1;
      o_rdata <= mem.exists(i_addr) ? mem[i_addr] ^ {15'h0, i_mode[1]} : ~o_rdata;
    end
  end
endmodule : aibl_host_mdl

//--- testbench/tb.sv
// Self-checking bench of the init-block loader
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_count++; \
  $display("wrong value at %0t: %h vs %h", $time, a, b); end end
module tb;
  import aibl_pkg::*;
  logic i_ref_clk = 0, i_rst = 1, i_wr = 0, i_rd = 0, i_wpar = 0, i_llc_present = 1;
  logic [2:0] i_addr = 0;
  logic [15:0] i_wdata = 0, rv = 0, i_dma_rdata, o_rdata, o_dma_wdata;
  logic [15:0] o_rx_burst_cap, o_tx_burst_cap;
  logic i_dma_bus_err = 0, i_dma_par_err = 0, i_dma_done, o_dma_req, o_dma_write;
  logic o_dma_burst, o_cfg_valid, o_parity_on, o_cmd_stat_block_burst, o_list_burst;
  logic o_lstat_burst, o_rx_burst, o_tx_burst, o_link_layer_on, o_irq_vec_valid;
  logic [31:0] o_dma_addr;
  logic [7:0] o_dma_len, o_list_len, o_bus_err_tries, o_par_err_tries, o_irq_vec;
  aibl_irq_ev_t i_irq_event = EV_NONE;
  logic [1:0] mode = 0;
  int err_count = 0, total_checks = 0;
  logic [15:0] w [11];
  logic [111:0] pat = 112'h0000c1e2d48bffffd1d7c5d9c3d4;
  logic [7:0] vx [9] = '{8'ha1, 8'hb2, 8'hc3, 8'hc3, 8'hd4, 8'hd4, 8'hd4, 8'he5, 8'hf6};
  wire [6:0] modes = {o_parity_on, o_cmd_stat_block_burst, o_list_burst, o_lstat_burst,
    o_rx_burst, o_tx_burst, o_link_layer_on};
  wire [55:0] nums = {o_list_len, o_rx_burst_cap, o_tx_burst_cap, o_bus_err_tries,
    o_par_err_tries};
  always #12.5 i_ref_clk = ~i_ref_clk;
  // Short timeout keeps the silent-host case brief
  aibl_loader #(.DMA_TMO_CYC(50)) DUT (.*);
  aibl_host_mdl mdl (.i_ref_clk(i_ref_clk), .i_req(o_dma_req), .i_write(o_dma_write),
    .i_addr(o_dma_addr), .i_wdata(o_dma_wdata), .i_mode(mode), .o_done(i_dma_done),
    .o_rdata(i_dma_rdata));
  task automatic wr(input logic [2:0] a, input logic [15:0] d, input logic bad);
    @(posedge i_ref_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    i_wpar <= ~^d ^ bad;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a);
    @(posedge i_ref_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1 rv = o_rdata;
  endtask : rd
  // f: [1:0] host, [2] no link firmware, [3] short block, [4] bad write parity,
  // [5] DMA bus error, [6] DMA parity error
  task automatic run(input int k, input logic [15:0] v, input logic [6:0] f, input aibl_code_t c);
    w = '{16'hff40, 16'ha1b2, 16'hc3d4, 16'he5f6, 16'h0010, 16'h0020, 16'h0302,
      16'h0000, 16'h1000, 16'h0000, 16'h2000};
    w[k] = v;
    @(posedge i_ref_clk);
    mode <= f[1:0];
    i_llc_present <= !f[2];
    i_dma_bus_err <= f[5];
    i_dma_par_err <= f[6];
    i_rst <= 1'b1;
    repeat (3) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    wr(3'h6, 16'h0001, 1'b0);
    wr(3'h2, 16'h0a00, 1'b0);
    for (int i = 0; i < 11 - f[3]; i++) wr(3'h4, w[i], f[4]);
    wr(3'h0, 16'h9080, 1'b0);
    rd(3'h0);
    for (int n = 0; n < 300 && rv[6] && !rv[4]; n++) rd(3'h0);
    `CHK({rv[5:0], rv[6] & !rv[4]}, {1'b0, c != 4'h0, c, 1'b0})
    $display("test done: word %0d code %h", k, c);
  endtask : run
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    run(0, 16'hff40, 5'h01, 4'h0);
    `CHK(modes, 7'h7f)
    `CHK(nums, 56'h1a_0010_0020_03_02)
    for (int k = 0; k < 7; k++)
      `CHK(mdl.mem[k < 3 ? 32'h1000 + 2 * k : 32'h2000 + 2 * k - 6], pat[111 - 16 * k -: 16])
    for (int e = 1; e < 10; e++)
    begin
      @(posedge i_ref_clk);
      i_irq_event <= aibl_irq_ev_t'(e);
      @(posedge i_ref_clk);
      i_irq_event <= EV_NONE;
      #1 `CHK({o_irq_vec_valid, o_irq_vec}, {1'b1, vx[e - 1]})
    end
    rd(3'h0);
    `CHK(rv[7], 1'b1)
    wr(3'h2, 16'h0a00, 1'b0);
    rd(3'h4);
    `CHK(rv, 16'hff40)
    rd(3'h4);
    `CHK(rv, 16'ha1b2)
    run(0, 16'h8000, 5'h00, 4'h0);
    `CHK(modes, 7'h00)
    `CHK(nums, 56'h02_0000_0020_03_02)
    run(0, 16'h0000, 5'h00, 4'h2);
    run(0, 16'h8080, 5'h00, 4'h2);
    run(0, 16'hc000, 5'h00, 4'h2);
    run(0, 16'h8040, 5'h04, 4'h2);
    run(4, 16'h0011, 5'h10, 4'h3);
    run(5, 16'h0021, 5'h00, 4'h4);
    run(6, 16'h0000, 5'h00, 4'h5);
    run(8, 16'h1001, 5'h00, 4'h6);
    run(10, 16'h2001, 5'h00, 4'h7);
    run(0, 16'hff40, 5'h08, 4'h1);
    run(0, 16'hff40, 5'h10, 4'h8);
    run(0, 16'hff40, 5'h02, 4'hc);
    run(0, 16'hff40, 5'h03, 4'h9);
    run(0, 16'hff40, 7'h20, 4'hb);
    run(0, 16'hff40, 7'h40, 4'ha);
    summarize();
  end
  initial
  begin
    #2000000;
    err_count++;
    summarize();
  end
endmodule : tb
